// >>> design/gdps_defines.svh
// timing counts and mode-register field positions for gear-down and power-save logic
`ifndef GDPS_DEFINES_SVH
`define GDPS_DEFINES_SVH
`define GDPS_MR_GEARDOWN_BIT   3
`define GDPS_MR_MAXSAVE_BIT    5
`define GDPS_MR_GEARDOWN_REG   3'h3
`define GDPS_MR_MAXSAVE_REG    3'h4
`define GDPS_ENTRY_DELAY_CYC   16'h0010
`define GDPS_CMD_GEAR_CYC      16'h0018
`define GDPS_EXIT_CYC          16'h0100
`define GDPS_DLL_EXIT_CYC      16'h0300
`endif

// >>> design/gdps_pkg.sv
// types for gear-down and power-save logic
package gdps_pkg;
  typedef enum logic [2:0] {
    GDPS_CMD_NONE    = 3'h0,
    GDPS_CMD_MRS     = 3'h1,
    GDPS_CMD_NOP     = 3'h2,
    GDPS_CMD_REFRESH = 3'h3,
    GDPS_CMD_SRE     = 3'h4,
    GDPS_CMD_SRX     = 3'h5,
    GDPS_CMD_OTHER   = 3'h6
  } gdps_cmd_t;
  typedef enum logic [4:0] {
    GDPS_ST_RUN    = 5'b00001,
    GDPS_ST_ENTRY  = 5'b00010,
    GDPS_ST_SLEEP  = 5'b00100,
    GDPS_ST_EXIT   = 5'b01000,
    GDPS_ST_DLLW   = 5'b10000
  } gdps_state_t;
endpackage : gdps_pkg

// >>> design/gdps_cke_edge.sv
// chip-select capture on clock-enable rising edge, clockless during hibernate
`timescale 1ns/100ps
`default_nettype none
module gdps_cke_edge (
  // pins
  input  wire logic cke,
  input  wire logic cs_n,
  input  wire logic rst,
  // clocked side
  input  wire logic clk,
  input  wire logic arm,
  output logic      exit_req
);
  logic cap_low;
  logic s1;
  logic s2;

  // cs low captured by cke edge; no clock needed while clock is stopped
  always_ff @(posedge cke or posedge rst) begin
    if (rst) begin
      cap_low <= 1'b0;
    end else begin
      cap_low <= ~cs_n; // RULE20 RULE19
    end
  end

  // bring capture into clk domain; arm gates only after the second flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
    end else begin
      s1 <= cap_low;
      s2 <= s1;
    end
  end

  assign exit_req = arm & s2;
endmodule : gdps_cke_edge
`default_nettype wire

// >>> design/gdps_mode_ctrl.sv
// gear-down clocking and maximum power-save mode control
// Behaviour
// RULE1: reset starts half-rate clocking, no sync needed
// RULE2: quarter rate only at fast grades
// RULE3: gear-down entry only at init or exit
// RULE4: latency and parity off before gear-down
// RULE5: gear-down set by mode register three bit
// RULE6: only refresh before gear-down command; self refresh entry also leaves the window open here
// RULE7: sync pulse even clocks after command
// RULE8: init continues quarter rate after gear interval
// RULE9: dll commands wait dll interval
// RULE10: self refresh entry returns to half rate
// RULE11: half-rate exit needs no sync pulse
// RULE12: even latencies in quarter rate
// RULE13: additive latency limited to read minus two
// RULE14: hibernate ignores commands, loses data
// RULE15: hibernate entered by mode-register command
// RULE16: parity, latency, gear-down off before hibernate
// RULE17: after entry delay only cke, cs, reset
// RULE18: clock held until hold interval passes
// RULE19: cs high at cke edge stays hibernating
// RULE20: cs low at cke edge starts exit
// RULE21: clock stable before exit completes
// RULE22: exit interval then dll exit interval
// RULE23: keep clocking and hibernate flags, reset clears
`timescale 1ns/100ps
`default_nettype none
`include "gdps_defines.svh"
module gdps_mode_ctrl
  import gdps_pkg::*;
#(
  parameter logic [15:0] ENTRY_CYC = `GDPS_ENTRY_DELAY_CYC,
  parameter logic [15:0] GEAR_CYC  = `GDPS_CMD_GEAR_CYC,
  parameter logic [15:0] EXIT_CYC  = `GDPS_EXIT_CYC,
  parameter logic [15:0] DLL_CYC   = `GDPS_DLL_EXIT_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // decoded command from the command interface
  input  wire gdps_cmd_t  cmd,
  input  wire logic       cmd_valid,
  input  wire logic [2:0] mr_sel,
  input  wire logic [17:0] mr_data,
  input  wire logic       pda_selected,
  // pins seen during hibernate
  input  wire logic       cke,
  input  wire logic       cs_n,
  // status
  output logic            quarter_rate,
  output logic            max_save,
  output logic            cmd_enable,
  output logic            dll_cmd_enable,
  output logic            data_valid
);
  gdps_state_t state;
  gdps_state_t next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        quarter_rate_q;
  logic        next_quarter_rate;
  logic        gear_pend;
  logic        next_gear_pend;
  logic [15:0] since_mrs;
  logic [15:0] next_since_mrs;
  logic        init_win;
  logic        next_init_win;
  logic        retain;
  logic        next_retain;
  logic        exit_req;
  logic        accept;

  gdps_cke_edge u_edge (
    .cke      (cke),
    .cs_n     (cs_n),
    .rst      (rst),
    .clk      (clk),
    .arm      (state == GDPS_ST_SLEEP),
    .exit_req (exit_req)
  );

  // commands only reach mode logic while awake
  assign accept = cmd_valid & ((state == GDPS_ST_RUN) | (state == GDPS_ST_DLLW)); // RULE14 RULE17

  // mode state next values
  always_comb begin
    next_state        = state;
    next_cnt          = (cnt != 16'h0000) ? cnt - 16'h0001 : cnt;
    next_quarter_rate = quarter_rate_q;
    next_gear_pend    = gear_pend;
    next_since_mrs    = since_mrs + 16'h0001;
    next_init_win     = init_win;
    next_retain       = retain;
    case (state)
      GDPS_ST_RUN, GDPS_ST_DLLW: begin
        if (state == GDPS_ST_DLLW && cnt == 16'h0000) begin
          next_state = GDPS_ST_RUN; // RULE22 RULE9
        end
        if (accept) begin
          case (cmd)
            GDPS_CMD_SRE: begin
              next_quarter_rate = 1'b0; // RULE10
              next_gear_pend    = 1'b0;
            end
            GDPS_CMD_SRX: begin
              next_init_win = 1'b1; // RULE3 gear-down window reopens
            end
            GDPS_CMD_MRS: begin
              if (mr_sel == `GDPS_MR_GEARDOWN_REG && init_win &&
                  mr_data[`GDPS_MR_GEARDOWN_BIT]) begin
                next_gear_pend = 1'b1; // RULE5
                next_since_mrs = 16'h0001;
              end
              if (mr_sel == `GDPS_MR_MAXSAVE_REG && pda_selected &&
                  mr_data[`GDPS_MR_MAXSAVE_BIT]) begin
                next_state = GDPS_ST_ENTRY; // RULE15
                next_cnt   = ENTRY_CYC;
                // drop a half-done gear-down so no later nop can apply it
                next_gear_pend = 1'b0;
              end
              next_init_win = 1'b0;
            end
            GDPS_CMD_NOP: begin
              // sync pulse aligns on even distance from the mode command
              if (gear_pend && !since_mrs[0]) begin
                next_quarter_rate = 1'b1; // RULE7 RULE8
                next_gear_pend    = 1'b0;
                next_state        = GDPS_ST_DLLW;
                next_cnt          = DLL_CYC;
              end
              next_init_win = 1'b0;
            end
            GDPS_CMD_REFRESH: begin
              next_init_win = init_win; // RULE6 refresh keeps window open
            end
            default: begin
              next_init_win = 1'b0;
            end
          endcase
        end
      end
      GDPS_ST_ENTRY: begin
        if (cnt == 16'h0000) begin
          next_state  = GDPS_ST_SLEEP; // RULE17
          next_retain = 1'b0; // RULE14
        end
      end
      GDPS_ST_SLEEP: begin
        if (exit_req) begin
          next_state = GDPS_ST_EXIT; // RULE20
          next_cnt   = EXIT_CYC;
        end
      end
      GDPS_ST_EXIT: begin
        if (cnt == 16'h0000) begin
          next_state    = GDPS_ST_DLLW; // RULE22
          next_cnt      = DLL_CYC - EXIT_CYC;
          next_init_win = 1'b1;
        end
      end
      default: begin
        next_state = GDPS_ST_RUN;
      end
    endcase
  end

  // mode state registers; reset forces half rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state          <= GDPS_ST_RUN;
      cnt            <= 16'h0000;
      quarter_rate_q <= 1'b0; // RULE1 RULE23
      gear_pend      <= 1'b0;
      since_mrs      <= 16'h0000;
      init_win       <= 1'b1;
      retain         <= 1'b1;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      quarter_rate_q <= next_quarter_rate;
      gear_pend      <= next_gear_pend;
      since_mrs      <= next_since_mrs;
      init_win       <= next_init_win;
      retain         <= next_retain;
    end
  end

  // status outputs
  assign quarter_rate   = quarter_rate_q;
  assign max_save       = (state == GDPS_ST_ENTRY) | (state == GDPS_ST_SLEEP); // RULE23
  assign dll_cmd_enable = (state == GDPS_ST_RUN);
  assign cmd_enable     = (state == GDPS_ST_RUN) |
                          ((state == GDPS_ST_DLLW) && (cnt <= DLL_CYC - GEAR_CYC));
  assign data_valid     = retain;
endmodule : gdps_mode_ctrl
`default_nettype wire

// >>> dv/gdps_mode_asserts.sv
// assertions on the ports of the gear-down and power-save controller
`timescale 1ns/100ps
`default_nettype none
module gdps_mode_asserts
  import gdps_pkg::*;
#(
  parameter logic [15:0] ENTRY_CYC = 16'h0010,
  parameter logic [15:0] EXIT_CYC  = 16'h0100
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // command side
  input wire gdps_cmd_t   cmd,
  input wire logic        cmd_valid,
  input wire logic [2:0]  mr_sel,
  input wire logic [17:0] mr_data,
  input wire logic        pda_selected,
  // status
  input wire logic        quarter_rate,
  input wire logic        max_save,
  input wire logic        cmd_enable,
  input wire logic        dll_cmd_enable,
  input wire logic        data_valid
);
  localparam int XB = EXIT_CYC + 8;
  logic [15:0] ms_cnt;
  wire logic   hib = cmd_valid && cmd == GDPS_CMD_MRS && mr_sel == 3'h4 && mr_data[5];
  wire logic   no_operation_cmd = cmd_valid && cmd == GDPS_CMD_NOP;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // hibernate length, so data loss has a bound without a long repetition
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      ms_cnt <= 16'h0;
    else
      ms_cnt <= max_save ? ms_cnt + 16'h1 : 16'h0;
  end
  // gear-down command followed by a sync one clock later
  sequence gear_set;
    !quarter_rate && cmd_valid && cmd == GDPS_CMD_MRS && mr_sel == 3'h3 && mr_data[3];
  endsequence
  sequence odd_sync;
    no_operation_cmd;
  endsequence
  hib_entry_a:
    assert property (hib && pda_selected && cmd_enable && dll_cmd_enable && !max_save
      |=> max_save && !cmd_enable) else $error("hibernate entry missed");
  pda_gate_a:
    assert property (hib && !pda_selected && !max_save |=> !max_save) else $error("unselected entry");
  data_lost_a:
    assert property (ms_cnt > ENTRY_CYC + 16'h3 |-> !data_valid) else $error("data still valid");
  dll_order_a:
    assert property (dll_cmd_enable && !max_save |-> cmd_enable) else $error("dll before plain");
  sre_half_a:
    assert property (cmd_valid && cmd == GDPS_CMD_SRE && cmd_enable && !max_save |=> !quarter_rate)
      else $error("self refresh kept quarter rate");
  gear_sync_a:
    assert property ($rose(quarter_rate) |-> $past(no_operation_cmd) || $past(no_operation_cmd, 2)) else $error("gear without sync");
  odd_sync_a:
    assert property (gear_set ##1 odd_sync |=> !quarter_rate [*2]) else $error("odd sync accepted");
  exit_time_a:
    assert property ($fell(max_save) |-> !cmd_enable ##[1:XB] cmd_enable) else $error("exit too long");
endmodule : gdps_mode_asserts
bind gdps_mode_ctrl gdps_mode_asserts #(.ENTRY_CYC(ENTRY_CYC), .EXIT_CYC(EXIT_CYC)) u_chk (
  .clk(clk), .rst(rst), .cmd(cmd), .cmd_valid(cmd_valid), .mr_sel(mr_sel), .mr_data(mr_data),
  .pda_selected(pda_selected), .quarter_rate(quarter_rate), .max_save(max_save),
  .cmd_enable(cmd_enable), .dll_cmd_enable(dll_cmd_enable), .data_valid(data_valid));
`default_nettype wire

// >>> dv/gdps_ctrl_model.sv
// memory controller model driving commands and the wake pins
`timescale 1ns/100ps
`default_nettype none
module gdps_ctrl_model
  import gdps_pkg::*;
(
  // clock
  input  wire logic       clk,
  // command side
  output var gdps_cmd_t   cmd,
  output var logic        cmd_valid,
  output var logic [2:0]  mr_sel,
  output var logic [17:0] mr_data,
  output var logic        pda_selected,
  // wake pins
  output var logic        cke,
  output var logic        cs_n
);
  // idle lines at time zero, clock enable high, nothing selected
  initial begin
    cmd = GDPS_CMD_NONE;
    cmd_valid = 1'b0;
    mr_sel = 3'h0;
    mr_data = 18'h0;
    pda_selected = 1'b0;
    cke = 1'b1;
    cs_n = 1'b1;
  end
  // one command driven and left on the lines until the next task call, launched off the sampling edge
  task automatic issue(input gdps_cmd_t c, input logic [2:0] s, input logic [17:0] d, input logic p);
    @(negedge clk);
    cmd = c;
    cmd_valid = 1'b1;
    mr_sel = s;
    mr_data = d;
    pda_selected = p;
  endtask : issue
  // released address shows the inverse so stale data never passes for fresh
  task automatic idle();
    @(negedge clk);
    cmd = GDPS_CMD_NONE;
    cmd_valid = 1'b0;
    mr_data = ~mr_data;
  endtask : idle
  // clock-enable rise with select held across it; clock never stops here
  task automatic wake(input logic sel_n);
    @(negedge clk);
    cke = 1'b0;
    cs_n = sel_n;
    @(negedge clk);
    cke = 1'b1;
    @(negedge clk);
    cs_n = 1'b1;
  endtask : wake
endmodule : gdps_ctrl_model
`default_nettype wire

// >>> dv/gear_down_and_power_save_tb.sv
// self-checking bench for the gear-down and power-save controller
`timescale 1ns/100ps
`default_nettype none
module gear_down_and_power_save_tb;
  import gdps_pkg::*;
  typedef struct {gdps_cmd_t c; logic [2:0] s; logic [17:0] d; logic k; logic q;} gdps_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  gdps_cmd_t   cmd;
  logic        cmd_valid, pda_selected, cke, cs_n, qr, ms, ce, dce, dv;
  logic [2:0]  mr_sel;
  logic [17:0] mr_data;
  int          miscompares = 0;
  int          n_checks = 0;
  // gear-down entry at a fast grade, parity and latency off
  gdps_row_t   rows [5] = '{'{GDPS_CMD_MRS, 3'h3, 18'h00008, 1'b1, 1'b0},
    '{GDPS_CMD_NONE, 3'h0, 18'h0, 1'b0, 1'b0}, '{GDPS_CMD_NOP, 3'h0, 18'h0, 1'b0, 1'b0},
    '{GDPS_CMD_NONE, 3'h0, 18'h0, 1'b0, 1'b0}, '{GDPS_CMD_NONE, 3'h0, 18'h0, 1'b1, 1'b1}};
  gdps_mode_ctrl #(.GEAR_CYC(16'h0004), .EXIT_CYC(16'h0008),
    .DLL_CYC(16'h0010)) uut (.clk(clk), .rst(rst), .cmd(cmd), .cmd_valid(cmd_valid),
    .mr_sel(mr_sel), .mr_data(mr_data), .pda_selected(pda_selected), .cke(cke), .cs_n(cs_n),
    .quarter_rate(qr), .max_save(ms), .cmd_enable(ce), .dll_cmd_enable(dce), .data_valid(dv));
  gdps_ctrl_model ctl (.clk(clk), .cmd(cmd), .cmd_valid(cmd_valid), .mr_sel(mr_sel),
    .mr_data(mr_data), .pda_selected(pda_selected), .cke(cke), .cs_n(cs_n));
  always #5 clk = ~clk;
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: status bit differs", $time);
    end
  endtask : chk
  // bounded wait on a status bit; running out ends the run
  task automatic wt(ref logic s, input logic v);
    for (int i = 0; i < 60 && s !== v; i++) @(negedge clk);
    if (s !== v) begin
      miscompares++;
      give_verdict();
    end
  endtask : wt
  // reset, table of gear-down steps, then hand-written cases
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk(ms, 1'b0);
    chk(dv, 1'b1);
    foreach (rows[i]) begin
      if (rows[i].c == GDPS_CMD_NONE) ctl.idle();
      else ctl.issue(rows[i].c, rows[i].s, rows[i].d, 1'b1);
      if (rows[i].k) chk(qr, rows[i].q);
    end
    chk(ce, 1'b0);
    wt(dce, 1'b1);
    chk(ce, 1'b1);
    ctl.issue(GDPS_CMD_SRE, 3'h0, 18'h0, 1'b1);
    ctl.idle();
    ctl.idle();
    chk(qr, 1'b0);
    ctl.issue(GDPS_CMD_SRX, 3'h0, 18'h0, 1'b1);
    ctl.idle();
    ctl.issue(GDPS_CMD_MRS, 3'h3, 18'h00008, 1'b1);
    ctl.issue(GDPS_CMD_NOP, 3'h0, 18'h0, 1'b1);
    ctl.idle();
    ctl.idle();
    chk(qr, 1'b0);
    ctl.issue(GDPS_CMD_MRS, 3'h4, 18'h00020, 1'b0);
    ctl.idle();
    ctl.idle();
    chk(ms, 1'b0);
    ctl.issue(GDPS_CMD_MRS, 3'h4, 18'h00020, 1'b1);
    ctl.idle();
    ctl.idle();
    chk(ms, 1'b1);
    wt(dv, 1'b0);
    ctl.issue(GDPS_CMD_MRS, 3'h3, 18'h00008, 1'b1);
    ctl.idle();
    ctl.issue(GDPS_CMD_NOP, 3'h0, 18'h0, 1'b1);
    ctl.idle();
    ctl.idle();
    chk(qr, 1'b0);
    ctl.wake(1'b1);
    repeat (4) ctl.idle();
    chk(ms, 1'b1);
    ctl.wake(1'b0);
    wt(ms, 1'b0);
    chk(ce, 1'b0);
    wt(ce, 1'b1);
    chk(dce, 1'b0);
    wt(dce, 1'b1);
    chk(dv, 1'b0);
    ctl.issue(GDPS_CMD_NOP, 3'h0, 18'h0, 1'b1);
    ctl.issue(GDPS_CMD_NOP, 3'h0, 18'h0, 1'b1);
    ctl.idle();
    ctl.idle();
    chk(qr, 1'b0);
    give_verdict();
  end
endmodule : gear_down_and_power_save_tb
`default_nettype wire
